// [hw/ltt_pkg.sv]
// types for the lost token timeout timer
package ltt_pkg;
    typedef enum logic [2:0] {
        LTT_IDLE = 3'h1,
        LTT_RUN = 3'h2,
        LTT_FIRE = 3'h4
    } ltt_state_e;
    typedef struct packed {
        ltt_state_e state;
        logic [21:0] cnt;
        logic sat_gen;
        logic running;
        logic bounce;
    } ltt_state_s;
endpackage

// [hw/ltt_regs.svh]
// timing and reset constants for the lost token timeout timer
`ifndef LTT_REGS_SVH
`define LTT_REGS_SVH
`define LTT_TIMEOUT_MS 100
`define LTT_CLK_PERIOD_NS 50
// cycles in the timeout period, rounded down from ms and clock period
`define LTT_TIMEOUT_CYC ((`LTT_TIMEOUT_MS * 1000000) / `LTT_CLK_PERIOD_NS)
`define LTT_CNT_W 22
`define LTT_CNT_RST 22'h000000
`define LTT_FLAG_RST 1'b0
`define LTT_BOUNCE_RST 1'b1
`endif

// [hw/ltt_timer.sv]
// per-port lost token timeout timer with substitute token generation
// Notes on behaviour
// - each port instantiates its own lost token timer
// - timeout period is 100 ms from latest start or restart
// - timer starts when power-on, total or absolute reset completes
// - forwarding or returning a token restarts the timer from zero
// - on expiry a substitute token is raised as if received
// - node-wide bounce select decides forward versus return of tokens
// - bounce select is forced for single-port or switch nodes
`timescale 1ns/1ns
`include "ltt_regs.svh"
// TERM_CNT is the last count value of a period; the default spans 100 ms at the
// nominal port clock, and another clock needs its own value set at the instance
module ltt_timer #(
    parameter logic [21:0] TERM_CNT = 22'(`LTT_TIMEOUT_CYC - 1)
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reset_done_i,
    input wire logic sat_pass_i,
    input wire logic single_or_switch_i,
    input wire logic bounce_cfg_i,
    output logic sat_gen_o,
    output logic running_o,
    output logic token_bounce_select_o
);
    ltt_pkg::ltt_state_s st_q, st_d;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // a token handed on or a completed reset kind both restart the period
    // restart request decode
    function automatic logic restart_req(
        input logic pass,
        input logic done
    );
        restart_req = pass | done;
    endfunction

    // the period has run out once the count sits at its terminal value;
    // an equality compare keeps the decode to one wide gate
    // expiry decode
    function automatic logic at_terminal(
        input logic [21:0] cnt
    );
        at_terminal = (cnt == TERM_CNT);
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.sat_gen = 1'b0;
        st_d.bounce = single_or_switch_i | bounce_cfg_i;
        case (st_q.state)
            ltt_pkg::LTT_IDLE: begin
                if (reset_done_i) begin
                    st_d.state = ltt_pkg::LTT_RUN;
                    st_d.cnt = `LTT_CNT_RST;
                    st_d.running = 1'b1;
                end
            end
            ltt_pkg::LTT_RUN: begin
                // restart on forwarded or returned token
                if (restart_req(sat_pass_i, reset_done_i)) begin
                    st_d.cnt = `LTT_CNT_RST;
                end else if (at_terminal(st_q.cnt)) begin
                    st_d.state = ltt_pkg::LTT_FIRE;
                    st_d.cnt = `LTT_CNT_RST;
                end else begin
                    st_d.cnt = st_q.cnt + 22'h000001;
                end
            end
            ltt_pkg::LTT_FIRE: begin
                // a pass seen in this cycle is dropped: the substitute token
                // already stands for it and opens the next period
                // substitute token pulse, then run a new period
                st_d.sat_gen = 1'b1;
                st_d.state = ltt_pkg::LTT_RUN;
                st_d.cnt = `LTT_CNT_RST;
            end
            default: begin
                // illegal code: fall back to idle and wait for a new start
                st_d.state = ltt_pkg::LTT_IDLE;
                st_d.running = 1'b0;
                st_d.cnt = `LTT_CNT_RST;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // private per-port state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_q.state <= ltt_pkg::LTT_IDLE;
            st_q.cnt <= `LTT_CNT_RST;
            st_q.sat_gen <= `LTT_FLAG_RST;
            st_q.running <= `LTT_FLAG_RST;
            // bounce leaves reset set: tokens are returned until told otherwise
            st_q.bounce <= `LTT_BOUNCE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // every port comes straight from the state register, so no decode glitch leaves the block
    assign sat_gen_o = st_q.sat_gen;
    assign running_o = st_q.running;
    assign token_bounce_select_o = st_q.bounce;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // expiry raises token
    a_expiry_fires: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_RUN && st_q.cnt == TERM_CNT && !sat_pass_i && !reset_done_i)
        |=> ##1 sat_gen_o)
        else $error("expiry did not raise substitute token");
    a_restart_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_RUN && sat_pass_i) |=> (st_q.cnt == 22'h000000 && !sat_gen_o))
        else $error("token pass did not restart timer");
    a_start_after_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_IDLE && reset_done_i) |=> running_o)
        else $error("timer did not start");
    a_idle_no_token: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !running_o |-> !sat_gen_o)
        else $error("token generated while stopped");
    a_bounce_forced: assert property (@(posedge core_clk_i) disable iff (rst_i)
        single_or_switch_i |=> token_bounce_select_o)
        else $error("bounce select not forced");
    a_bounce_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!single_or_switch_i && !bounce_cfg_i) |=> !token_bounce_select_o)
        else $error("bounce select stuck");
    a_count_steps: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_RUN && !sat_pass_i && !reset_done_i && st_q.cnt != TERM_CNT)
        |=> st_q.cnt == $past(st_q.cnt) + 22'h000001)
        else $error("timer count did not advance");
    a_count_bound: assert property (@(posedge core_clk_i) disable iff (rst_i)
        st_q.cnt <= TERM_CNT)
        else $error("count passed terminal value");
    c_start: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(running_o));
    c_fire: cover property (@(posedge core_clk_i) disable iff (rst_i) sat_gen_o);
    c_restart: cover property (@(posedge core_clk_i) disable iff (rst_i) running_o && sat_pass_i);

    // ----------------------------------------
    // expiry and restart checks
    // ----------------------------------------
    // one period, counted in edges after the edge s that starts or restarts it:
    //   after s + k, k up to TERM_CNT : the count holds k
    //   after s + TERM_CNT + 1        : fire state, a pass in this cycle is dropped
    //   after s + TERM_CNT + 2        : substitute token for one cycle, count back at 0
    // so two tokens with no pass between them lie TERM_CNT + 2 cycles apart
    // expiry enters fire
    a_fire_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_RUN && at_terminal(st_q.cnt) && !restart_req(sat_pass_i, reset_done_i))
        |=> (st_q.state == ltt_pkg::LTT_FIRE && st_q.cnt == 22'h000000 && !sat_gen_o))
        else $error("terminal count did not enter the fire state");
    a_fire_ignores_pass: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_FIRE)
        |=> (st_q.state == ltt_pkg::LTT_RUN && st_q.cnt == 22'h000000 && sat_gen_o))
        else $error("fire cycle did not raise substitute token");
    a_token_one_cycle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sat_gen_o |=> !sat_gen_o)
        else $error("substitute token held too long");
    a_token_from_fire: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sat_gen_o |-> ($past(st_q.state) == ltt_pkg::LTT_FIRE))
        else $error("substitute token without expiry");
    a_token_new_period: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sat_gen_o |-> (st_q.state == ltt_pkg::LTT_RUN && st_q.cnt == 22'h000000))
        else $error("substitute token did not open a new period");
    a_restart_any: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_RUN && restart_req(sat_pass_i, reset_done_i))
        |=> (st_q.state == ltt_pkg::LTT_RUN && st_q.cnt == 22'h000000))
        else $error("restart did not clear the period");
    a_no_early_fire: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_RUN && !at_terminal(st_q.cnt))
        |=> (st_q.state != ltt_pkg::LTT_FIRE))
        else $error("timer expired before terminal count");

    // ----------------------------------------
    // start and reset checks
    // ----------------------------------------
    // idle until reset completes
    a_idle_waits: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == ltt_pkg::LTT_IDLE && !reset_done_i)
        |=> (st_q.state == ltt_pkg::LTT_IDLE && !running_o && st_q.cnt == 22'h000000))
        else $error("timer left idle without reset completion");
    a_running_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
        running_o |=> running_o)
        else $error("timer stopped while running");
    // reset is synchronous: its effect is looked at one edge after it is sampled
    // reset stops timer
    a_reset_stops: assert property (@(posedge core_clk_i)
        rst_i |=> (st_q.state == ltt_pkg::LTT_IDLE && !running_o && !sat_gen_o && token_bounce_select_o))
        else $error("reset did not stop the timer");

    // further scenarios: a pass dropped in the fire cycle, bounce select released
    c_fire_refused: cover property (@(posedge core_clk_i) disable iff (rst_i)
        st_q.state == ltt_pkg::LTT_FIRE && sat_pass_i);
    c_bounce_drop: cover property (@(posedge core_clk_i) disable iff (rst_i) $fell(token_bounce_select_o));
endmodule

// [sim/ltt_partner.sv]
// far-side port model that hands tokens through
`timescale 1ns/1ns
module ltt_partner (
    input wire logic core_clk_i,
    output logic sat_pass_o
);
    initial sat_pass_o = 1'b0;
    // pass a token after gap edges as a one-cycle pulse
    task automatic pass_after(input int gap);
        repeat (gap) @(posedge core_clk_i);
        #5 sat_pass_o = 1'b1;
        @(posedge core_clk_i);
        #5 sat_pass_o = 1'b0;
    endtask
endmodule

// [sim/ltt_timer_bench.sv]
// self-checking bench for the lost token timer
`timescale 1ns/1ns
module ltt_timer_bench;
    logic core_clk_i = 1'b0, rst_i = 1'b1, reset_done_i = 1'b0, single_or_switch_i = 1'b0, bounce_cfg_i = 1'b0;
    logic sat_pass_i, sat_gen_o, running_o, token_bounce_select_o;
    int num_errors = 0, tests_run = 0, cyc = 0, exp_q[$];
    logic [15:0] lfsr = 16'h6e9a;
    localparam int TERM = 20;
    // next value of the stimulus shift register
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;
    ltt_partner u_ltt_partner (.core_clk_i(core_clk_i), .sat_pass_o(sat_pass_i));
    ltt_timer #(.TERM_CNT(22'(TERM))) u_ltt_timer (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reset_done_i(reset_done_i), .sat_pass_i(sat_pass_i), .single_or_switch_i(single_or_switch_i),
        .bounce_cfg_i(bounce_cfg_i), .sat_gen_o(sat_gen_o), .running_o(running_o),
        .token_bounce_select_o(token_bounce_select_o));
    task automatic check_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic check_token(input int got);
        int want;
        tests_run++;
        if (exp_q.size() == 0) begin
            num_errors++;
            $display("mismatch at %0t: substitute token with none expected", $time);
        end else begin
            want = exp_q.pop_front();
            if (got != want) begin
                num_errors++;
                $display("mismatch at %0t: token at cycle %0d, expected %0d", $time, got, want);
            end
        end
    endtask
    task automatic give_verdict();
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // each substitute token must meet the oldest noted cycle, looked at mid-cycle
    always @(negedge core_clk_i) begin
        if (sat_gen_o !== 1'b0) begin
            check_token(cyc);
        end
    end
    initial begin
        #1000000 num_errors++;
        give_verdict();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge core_clk_i);
        #5 rst_i = 1'b0;
        check_bit(running_o, 1'b0, "idle");
        check_bit(token_bounce_select_o, 1'b1, "reset bounce");
        for (int i = 0; i < 40; i++) begin
            {single_or_switch_i, bounce_cfg_i} = lfsr[1:0];
            lfsr = lfsr_next(lfsr);
            @(posedge core_clk_i);
            #5 check_bit(token_bounce_select_o, single_or_switch_i | bounce_cfg_i, "bounce");
        end
        u_ltt_partner.pass_after(1);
        check_bit(running_o, 1'b0, "pass in idle");
        repeat (30) @(posedge core_clk_i);
        $display("test bounce and idle done");
        #5 reset_done_i = 1'b1;
        exp_q.push_back(cyc + TERM + 3);
        exp_q.push_back(cyc + 2 * TERM + 5);
        @(posedge core_clk_i);
        #5 reset_done_i = 1'b0;
        check_bit(running_o, 1'b1, "start");
        repeat (46) @(posedge core_clk_i);
        $display("test start done");
        for (int i = 0; i < 4; i++) begin
            u_ltt_partner.pass_after(1 + lfsr[3:0]);
            lfsr = lfsr_next(lfsr);
        end
        exp_q.push_back(cyc + TERM + 2);
        exp_q.push_back(cyc + 2 * TERM + 4);
        repeat (45) @(posedge core_clk_i);
        #5 rst_i = 1'b1;
        @(posedge core_clk_i);
        #5 rst_i = 1'b0;
        check_bit(running_o, 1'b0, "reset stops");
        check_bit(token_bounce_select_o, 1'b1, "mid-run reset bounce");
        repeat (40) @(posedge core_clk_i);
        check_bit(exp_q.size() == 0, 1'b1, "tokens left");
        $display("test restart done");
        #5 reset_done_i = 1'b1;
        exp_q.push_back(cyc + TERM + 3);
        exp_q.push_back(cyc + 2 * TERM + 5);
        @(posedge core_clk_i);
        #5 reset_done_i = 1'b0;
        // this pass lands in the fire cycle and must not cancel the substitute token
        u_ltt_partner.pass_after(TERM + 1);
        repeat (TERM + 4) @(posedge core_clk_i);
        check_bit(exp_q.size() == 0, 1'b1, "pass in fire cycle");
        $display("test fire cycle done");
        give_verdict();
    end
endmodule
